// [hw/cip_cfg.svh]
`ifndef CIP_CFG_SVH
`define CIP_CFG_SVH
// =====================================================================
// Register map (byte addresses on the Wishbone slave).
`define CIP_OFF_IOTRAP     8'h00
`define CIP_OFF_IDLECFG    8'h04
`define CIP_OFF_PERFREQ    8'h08
`define CIP_OFF_PERFSTAT   8'h0c
`define CIP_OFF_THRESH     8'h10
`define CIP_OFF_CORESTAT   8'h14
// =====================================================================
// Field positions.
`define CIP_IOTRAP_EN      31
`define CIP_IDLECFG_DEMC3  0
`define CIP_IDLECFG_DEMC1  1
`define CIP_IDLECFG_WAKEIF 2
// Reset values.
`define CIP_IOTRAP_RST     32'h0000_0000
`define CIP_IDLECFG_RST    3'h4
`define CIP_THRESH_RST     16'h0804
// Idle level codes.
`define CIP_LVL_ACTIVE     3'h0
`define CIP_LVL_HALT       3'h1
`define CIP_LVL_CSTOP      3'h2
`define CIP_LVL_POFF       3'h3
`define CIP_LVL_MAX        3'h7
// Timing (ns) and derived cycle counts at 5 ns.
`define CIP_CLK_NS         5
`define CIP_VSETTLE_NS     100
`define CIP_VSETTLE_CYC    (`CIP_VSETTLE_NS / `CIP_CLK_NS)
`define CIP_LOCK_NS        200
`define CIP_LOCK_CYC       (`CIP_LOCK_NS / `CIP_CLK_NS)
`define CIP_FLUSH_CYC      8'h10
`define CIP_SAVE_CYC       8'h10
`define CIP_WINDOW_CYC     16'h03e8
`endif

// [hw/cip_pkg.sv]
package cip_pkg;
  // =====================================================================
  // Per-core power sequence states.
  typedef enum logic [2:0] {
    CORE_RUN,
    CORE_ENTER,
    CORE_FLUSH,
    CORE_SAVE,
    CORE_IDLE,
    CORE_RESTORE
  } cip_core_t;
  // Performance transition states.
  typedef enum logic [1:0] {
    PERF_STEADY,
    PERF_VOLT,
    PERF_LOCK
  } cip_perf_t;
endpackage : cip_pkg

// [hw/cip_core_idle_perf.sv]
`timescale 1ns/1ps
`include "cip_cfg.svh"

module cip_core_idle_perf #(
  parameter int NCORE = 2,  // Cores.
  parameter int NTHR  = 2,  // Threads per core.
  parameter int PW    = 4   // Performance-point width.
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Wishbone slave.
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output      logic [31:0]             wb_dat_o,
  output      logic                    wb_ack_o,
  // Thread requests: one-cycle strobes with a level.
  input  wire logic [NCORE*NTHR-1:0]   mwaitReq,
  input  wire logic [NCORE*NTHR*3-1:0] mwaitLevel,
  input  wire logic [NCORE*NTHR-1:0]   haltReq,
  input  wire logic [NCORE*NTHR-1:0]   intMaskFlag,
  // Legacy idle-level read.
  input  wire logic [NCORE*NTHR-1:0]   legacyReadReq,
  input  wire logic [15:0]             legacyReadAddr,
  output      logic [NCORE*NTHR-1:0]   legacyReadPassThru,
  // Wake events.
  input  wire logic [NCORE*NTHR-1:0]   threadIrq,
  input  wire logic                    pkgIrq,
  input  wire logic [NCORE*NTHR-1:0]   monitorHit,
  input  wire logic [NCORE*NTHR-1:0]   deadlineExpired,
  input  wire logic [NCORE*NTHR-1:0]   smiReturnHalt,
  input  wire logic [NCORE-1:0]        snoopIn,
  // Performance requests per core.
  input  wire logic [NCORE*PW-1:0]     perfReqIn,
  // Power control outputs.
  output      logic [PW-1:0]           voltTarget,
  output      logic [PW-1:0]           pllTarget,
  output      logic [NCORE-1:0]        snoopServiced,
  output      logic [NCORE-1:0]        cacheFlush,
  output      logic [NCORE-1:0]        clockStop,
  output      logic [NCORE-1:0]        stateSave,
  output      logic [NCORE-1:0]        stateRestore,
  output      logic [NCORE-1:0]        corePowerOff,
  output      logic [NCORE*NTHR-1:0]   threadActive
);
  localparam int NT = NCORE * NTHR;

  // =====================================================================
  // Registers.
  logic [31:0]       ioTrapCfg;    // En, base[15:0], len[23:16].
  logic [2:0]        idleCfg;      // Demotion enables and wake policy.
  logic [15:0]       thresh;       // C1 rate [15:8], C3 rate [7:0].
  logic [NCORE*PW-1:0] swPerf;     // Software performance requests.
  cip_pkg::cip_perf_t perfSt;      // Transition state.
  logic [7:0]        perfCnt;      // Transition timer.
  logic [PW-1:0]     perfGoal;     // Target latched at start.
  logic              perfPend;     // Deferred request waiting.
  logic [2:0]        thrLvl [NT];  // Thread requested level.
  logic [NT-1:0]     thrWakeIf;    // Break even if masked.
  cip_pkg::cip_core_t coreSt [NCORE];
  logic [2:0]        coreLvl [NCORE]; // Resolved, post-demotion.
  logic [7:0]        coreCnt [NCORE];
  logic [7:0]        irqCount [NCORE]; // Interrupts in window.
  logic [15:0]       winCnt;
  logic [7:0]        rateSnap [NCORE]; // Last window rate.

  // Wishbone write strobe, one per access.
  logic wbWr;
  assign wbWr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

  // Range check used for every legacy read while trapping is enabled.
  function automatic logic inRange(input logic [15:0] a,
                                   input logic [31:0] c);
    logic [16:0] top;
    top = {1'b0, c[15:0]} + {9'h000, c[23:16]};
    inRange = (a >= c[15:0]) && ({1'b0, a} < top);
  endfunction : inRange

  // Lowest of a core's thread levels.
  function automatic logic [2:0] minLvl(input int c,
                                        input logic [2:0] l [NT]);
    logic [2:0] m;
    m = `CIP_LVL_MAX;
    for (int t = 0; t < NTHR; t++)
      if (l[c*NTHR+t] < m) m = l[c*NTHR+t];
    minLvl = m;
  endfunction : minLvl

  // =====================================================================
  // Bus slave: one-wait answer, unmapped reads as zero.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      ioTrapCfg <= `CIP_IOTRAP_RST;
      idleCfg   <= `CIP_IDLECFG_RST;      // Demotion off.
      thresh    <= `CIP_THRESH_RST;
      swPerf    <= '0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wbWr && wb_sel_i == 4'hf)
      begin
        unique case (wb_adr_i)
          `CIP_OFF_IOTRAP:  ioTrapCfg <= wb_dat_i;
          `CIP_OFF_IDLECFG: idleCfg <= wb_dat_i[2:0]; // Policy.
          `CIP_OFF_THRESH:  thresh <= wb_dat_i[15:0];
          `CIP_OFF_PERFREQ: swPerf <= wb_dat_i[NCORE*PW-1:0];
          default: ;
        endcase
      end
      // Reads mirror live state.
      unique case (wb_adr_i)
        `CIP_OFF_IOTRAP:   wb_dat_o <= ioTrapCfg;
        `CIP_OFF_IDLECFG:  wb_dat_o <= {29'h0, idleCfg};
        `CIP_OFF_THRESH:   wb_dat_o <= {16'h0, thresh};
        `CIP_OFF_PERFREQ:  wb_dat_o <= 32'(swPerf);
        `CIP_OFF_PERFSTAT: wb_dat_o <= 32'({perfPend,
                                        perfSt == cip_pkg::PERF_STEADY,
                                        pllTarget, voltTarget});
        `CIP_OFF_CORESTAT: wb_dat_o <= 32'({corePowerOff,
                                        clockStop, threadActive});
        default:           wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // =====================================================================
  // Performance point: highest request among active cores.
  logic [PW-1:0] perfWant;
  always_comb
  begin
    perfWant = '0;
    for (int c = 0; c < NCORE; c++)
    begin
      logic [PW-1:0] r;
      r = swPerf[c*PW +: PW] | perfReqIn[c*PW +: PW];
      if (coreSt[c] == cip_pkg::CORE_RUN && r > perfWant)
        perfWant = r;
    end
  end

  // Transition sequencer: voltage, then PLL lock.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      perfSt     <= cip_pkg::PERF_STEADY;
      perfCnt    <= 8'h00;
      perfGoal   <= '0;
      perfPend   <= 1'b0;
      voltTarget <= '0;
      pllTarget  <= '0;
    end
    else
    begin
      unique case (perfSt)
        cip_pkg::PERF_STEADY:
        begin
          perfPend <= 1'b0;
          if (perfWant != pllTarget)
          begin
            perfGoal   <= perfWant;
            voltTarget <= perfWant;
            perfCnt    <= 8'(`CIP_VSETTLE_CYC);
            perfSt     <= cip_pkg::PERF_VOLT;
          end
        end
        cip_pkg::PERF_VOLT:
        begin
          perfPend <= perfWant != perfGoal;
          if (perfCnt == 8'h00)
          begin
            pllTarget <= perfGoal;
            perfCnt   <= 8'(`CIP_LOCK_CYC);
            perfSt    <= cip_pkg::PERF_LOCK;
          end
          else
            perfCnt <= perfCnt - 8'h01;
        end
        cip_pkg::PERF_LOCK:
        begin
          perfPend <= perfWant != perfGoal;
          if (perfCnt == 8'h00)
            perfSt <= cip_pkg::PERF_STEADY;           // Deferred next.
          else
            perfCnt <= perfCnt - 8'h01;
        end
      endcase
    end
  end

  // =====================================================================
  // Thread requests and wakes.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      legacyReadPassThru <= '0;
      thrWakeIf          <= '0;
      threadActive       <= '1;
      for (int t = 0; t < NT; t++) thrLvl[t] <= `CIP_LVL_ACTIVE;
    end
    else
    begin
      for (int t = 0; t < NT; t++)
      begin
        logic trap;
        logic brk;
        int   c;
        c    = t / NTHR;
        trap = legacyReadReq[t] && ioTrapCfg[`CIP_IOTRAP_EN]
               && inRange(legacyReadAddr, ioTrapCfg);
        legacyReadPassThru[t] <= legacyReadReq[t] & ~trap;
        // Break: thread interrupt only its own, package any.
        brk = ((threadIrq[t] || pkgIrq)
               && (!intMaskFlag[t] || thrWakeIf[t]))
              || monitorHit[t] || deadlineExpired[t];
        // Clock-stop and deeper ignore snoops by construction.
        if (thrLvl[t] != `CIP_LVL_ACTIVE)
        begin
          if (smiReturnHalt[t])
            thrLvl[t] <= `CIP_LVL_HALT;
          else if (brk)
          begin
            thrLvl[t]       <= `CIP_LVL_ACTIVE;
            threadActive[t] <= 1'b1;
          end
        end
        else if (coreSt[c] == cip_pkg::CORE_RUN)
        begin
          // Only from active, so each idle passes through it.
          if (trap)
          begin
            // Zero hint: the level alone, a trapped read gives its offset from the base plus 2.
            thrLvl[t]       <= (legacyReadAddr[2:0] -
                                ioTrapCfg[2:0]) + 3'h2;
            thrWakeIf[t]    <= idleCfg[`CIP_IDLECFG_WAKEIF];
            threadActive[t] <= 1'b0;
          end
          else if (mwaitReq[t] && mwaitLevel[t*3 +: 3] != 3'h0)
          begin
            thrLvl[t]       <= mwaitLevel[t*3 +: 3];
            thrWakeIf[t]    <= 1'b0;
            threadActive[t] <= 1'b0;
          end
          else if (haltReq[t])
          begin
            thrLvl[t]       <= `CIP_LVL_HALT;
            thrWakeIf[t]    <= 1'b0;
            threadActive[t] <= 1'b0;
          end
        end
      end
    end
  end

  // =====================================================================
  // Interrupt-rate windows for demotion, one sample per core.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      winCnt <= 16'h0000;
      for (int c = 0; c < NCORE; c++)
      begin
        irqCount[c] <= 8'h00;
        rateSnap[c] <= 8'h00;
      end
    end
    else
    begin
      winCnt <= (winCnt == `CIP_WINDOW_CYC) ? 16'h0000 : winCnt + 16'h1;
      for (int c = 0; c < NCORE; c++)
      begin
        logic hit;
        hit = pkgIrq || |threadIrq[c*NTHR +: NTHR];
        if (winCnt == `CIP_WINDOW_CYC)
        begin
          rateSnap[c] <= irqCount[c];
          irqCount[c] <= 8'(hit);
        end
        else if (hit && irqCount[c] != 8'hff)
          irqCount[c] <= irqCount[c] + 8'h01;
      end
    end
  end

  // =====================================================================
  // Core sequencer: resolve, demote, flush/save, idle, restore.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      snoopServiced <= '0;
      cacheFlush    <= '0;
      clockStop     <= '0;
      stateSave     <= '0;
      stateRestore  <= '0;
      corePowerOff  <= '0;
      for (int c = 0; c < NCORE; c++)
      begin
        coreSt[c]  <= cip_pkg::CORE_RUN;
        coreLvl[c] <= `CIP_LVL_ACTIVE;
        coreCnt[c] <= 8'h00;
      end
    end
    else
    begin
      for (int c = 0; c < NCORE; c++)
      begin
        logic [2:0] r;
        r = minLvl(c, thrLvl);
        if (r > `CIP_LVL_POFF) r = `CIP_LVL_POFF;
        // High rate demotes; halt needs the higher rate.
        if (idleCfg[`CIP_IDLECFG_DEMC1] && r >= `CIP_LVL_CSTOP
            && rateSnap[c] >= thresh[15:8])
          r = `CIP_LVL_HALT;
        else if (idleCfg[`CIP_IDLECFG_DEMC3] && r >= `CIP_LVL_POFF
                 && rateSnap[c] >= thresh[7:0])
          r = `CIP_LVL_CSTOP;
        // Snoops served while running or halted only.
        snoopServiced[c] <= snoopIn[c] &&
                            (coreSt[c] == cip_pkg::CORE_RUN ||
                             coreLvl[c] == `CIP_LVL_HALT);
        unique case (coreSt[c])
          cip_pkg::CORE_RUN:
            if (r != `CIP_LVL_ACTIVE)
            begin
              coreLvl[c] <= r;   // Actions only once resolved.
              coreSt[c]  <= cip_pkg::CORE_ENTER;
            end
          cip_pkg::CORE_ENTER:
            if (coreLvl[c] == `CIP_LVL_HALT)
              coreSt[c] <= cip_pkg::CORE_IDLE;
            else
            begin
              cacheFlush[c] <= 1'b1;
              coreCnt[c]    <= `CIP_FLUSH_CYC;
              coreSt[c]     <= cip_pkg::CORE_FLUSH;
            end
          cip_pkg::CORE_FLUSH:
            if (coreCnt[c] == 8'h00)
            begin
              cacheFlush[c] <= 1'b0;
              if (coreLvl[c] == `CIP_LVL_POFF)
              begin
                stateSave[c] <= 1'b1;
                coreCnt[c]   <= `CIP_SAVE_CYC;
                coreSt[c]    <= cip_pkg::CORE_SAVE;
              end
              else
              begin
                clockStop[c] <= 1'b1;
                coreSt[c]    <= cip_pkg::CORE_IDLE;
              end
            end
            else
              coreCnt[c] <= coreCnt[c] - 8'h01;
          cip_pkg::CORE_SAVE:
            if (coreCnt[c] == 8'h00)
            begin
              stateSave[c]    <= 1'b0;
              clockStop[c]    <= 1'b1;
              corePowerOff[c] <= 1'b1;
              coreSt[c]       <= cip_pkg::CORE_IDLE;
            end
            else
              coreCnt[c] <= coreCnt[c] - 8'h01;
          cip_pkg::CORE_IDLE:
            if (r == `CIP_LVL_ACTIVE)
            begin
              clockStop[c]    <= 1'b0;
              corePowerOff[c] <= 1'b0;
              if (corePowerOff[c])
              begin
                stateRestore[c] <= 1'b1;
                coreCnt[c]      <= `CIP_SAVE_CYC;
                coreSt[c]       <= cip_pkg::CORE_RESTORE;
              end
              else
              begin
                coreLvl[c] <= `CIP_LVL_ACTIVE;
                coreSt[c]  <= cip_pkg::CORE_RUN;
              end
            end
          cip_pkg::CORE_RESTORE:
            if (coreCnt[c] == 8'h00)
            begin
              stateRestore[c] <= 1'b0;
              coreLvl[c]      <= `CIP_LVL_ACTIVE;
              coreSt[c]       <= cip_pkg::CORE_RUN;
            end
            else
              coreCnt[c] <= coreCnt[c] - 8'h01;
        endcase
      end
    end
  end
endmodule : cip_core_idle_perf

// [dv/cip_core_idle_perf_checker.sv]
`timescale 1ns/1ps
// =====================================================================
// Port-level checks for the idle and performance-state controller.
module cip_core_idle_perf_checker #(
  parameter int NCORE = 2,  // Cores.
  parameter int NTHR  = 2,  // Threads per core.
  parameter int PW    = 4   // Performance-point width.
) (
  // Clock and reset.
  input wire logic                  clk,
  input wire logic                  rst_b,
  // Bus handshake.
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  // Thread and core signals.
  input wire logic [NCORE*NTHR-1:0] legacyReadReq,
  input wire logic [NCORE*NTHR-1:0] legacyReadPassThru,
  input wire logic [NCORE*NTHR-1:0] threadActive,
  input wire logic [NCORE-1:0]      snoopIn,
  input wire logic [NCORE-1:0]      snoopServiced,
  input wire logic [NCORE-1:0]      cacheFlush,
  input wire logic [NCORE-1:0]      clockStop,
  input wire logic [NCORE-1:0]      stateSave,
  input wire logic [NCORE-1:0]      corePowerOff,
  // Operating point.
  input wire logic [PW-1:0]         voltTarget,
  input wire logic [PW-1:0]         pllTarget
);
  logic [NCORE-1:0] coreAnyActive;  // A core with any running thread.

  // =====================================================================
  // One running thread keeps the whole core out of power saving.
  always_comb
  begin
    for (int c = 0; c < NCORE; c++)
      coreAnyActive[c] = |threadActive[c*NTHR +: NTHR];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // =====================================================================
  // Bus answers and sequencing relations.
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("bus request not answered next cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_pll_after_volt: assert property ($changed(pllTarget) |->
    pllTarget == voltTarget) else $error("pll moved ahead of voltage");
  a_pll_waits_lock: assert property ($changed(voltTarget) &&
    $past(rst_b) |=> $stable(pllTarget) [*8])
    else $error("pll changed during voltage settle");
  a_volt_held: assert property ($changed(voltTarget) &&
    $past(rst_b) |=> $stable(voltTarget) [*8])
    else $error("transition not deferred");
  a_pll_in_time: assert property ($changed(voltTarget) &&
    $past(rst_b) |-> ##[1:60] pllTarget == voltTarget)
    else $error("pll never reached target");
  a_pass_has_read: assert property (
    (legacyReadPassThru & ~$past(legacyReadReq)) == '0)
    else $error("pass-through without a legacy read");
  a_flush_when_idle: assert property (
    (cacheFlush & ~$past(cacheFlush) & coreAnyActive) == '0)
    else $error("flush started with a thread running");
  a_stop_after_flush: assert property (
    (clockStop & ~$past(clockStop) & ~$past(cacheFlush)
     & ~($past(stateSave) & corePowerOff)) == '0)
    else $error("clocks stopped without a flush");
  a_off_after_save: assert property (
    (corePowerOff & ~$past(corePowerOff) & ~$past(stateSave)) == '0)
    else $error("power removed without a save");
  a_no_snoop_stopped: assert property (
    (snoopServiced & $past(clockStop)) == '0)
    else $error("snoop serviced while clocks stopped");
  a_snoop_has_cause: assert property (
    (snoopServiced & ~$past(snoopIn)) == '0)
    else $error("snoop service without a snoop");
  a_awake_after_reset: assert property ($rose(rst_b) |->
    &threadActive) else $error("threads not active after reset");

  // Main scenarios reached.
  c_clock_stop: cover property (|clockStop);
  c_power_off: cover property (|corePowerOff);
  c_pass_thru: cover property (|legacyReadPassThru);
endmodule : cip_core_idle_perf_checker

bind cip_core_idle_perf cip_core_idle_perf_checker #(
  .NCORE(NCORE), .NTHR(NTHR), .PW(PW)) i_chk (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .legacyReadReq(legacyReadReq),
  .legacyReadPassThru(legacyReadPassThru), .threadActive(threadActive),
  .snoopIn(snoopIn), .snoopServiced(snoopServiced),
  .cacheFlush(cacheFlush), .clockStop(clockStop), .stateSave(stateSave),
  .corePowerOff(corePowerOff), .voltTarget(voltTarget),
  .pllTarget(pllTarget));

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "cip_cfg.svh"
`define CHECK(what, exp, got) \
  begin \
    totalChecks++; \
    if ((got) !== (exp)) begin nErrors++; \
      $display("mismatch %s expected %0h seen %0h", what, exp, got); end \
  end
// =====================================================================
// Bench for the idle and performance-state controller.
module testbench;
  localparam int NT = 4;       // Two cores of two threads.
  localparam int LIMIT = 300;  // Edges that any one wait may take.
  logic              clk, rst_b, cyc, stb, we, ack, pkgIrq;
  logic [7:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       wdat, rdat, junk;
  logic [NT-1:0]     mwaitReq, haltReq, intMaskFlag, legacyReadReq;
  logic [NT-1:0]     threadIrq, monitorHit, deadlineExpired, smiReturnHalt;
  logic [NT-1:0]     legacyReadPassThru, threadActive;
  logic [NT*3-1:0]   mwaitLevel;
  logic [15:0]       legacyReadAddr;
  logic [1:0]        snoopIn, snoopServiced, cacheFlush, clockStop;
  logic [1:0]        stateSave, stateRestore, corePowerOff;
  logic [7:0]        perfReqIn;
  logic [3:0]        voltTarget, pllTarget;
  int                nErrors, totalChecks;

  cip_core_idle_perf #(.NCORE(2), .NTHR(2), .PW(4)) i_cip_core_idle_perf (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .mwaitReq(mwaitReq), .mwaitLevel(mwaitLevel),
    .haltReq(haltReq), .intMaskFlag(intMaskFlag),
    .legacyReadReq(legacyReadReq), .legacyReadAddr(legacyReadAddr),
    .legacyReadPassThru(legacyReadPassThru), .threadIrq(threadIrq),
    .pkgIrq(pkgIrq), .monitorHit(monitorHit),
    .deadlineExpired(deadlineExpired), .smiReturnHalt(smiReturnHalt),
    .snoopIn(snoopIn), .perfReqIn(perfReqIn), .voltTarget(voltTarget),
    .pllTarget(pllTarget), .snoopServiced(snoopServiced),
    .cacheFlush(cacheFlush), .clockStop(clockStop), .stateSave(stateSave),
    .stateRestore(stateRestore), .corePowerOff(corePowerOff),
    .threadActive(threadActive));

  // 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task complete_run();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // A hung wait is a mismatch and ends the run at once.
  task timeout(input string what);
    nErrors++;
    $display("mismatch %s expected done seen hang", what);
    complete_run();
  endtask : timeout

  // One classic cycle; data is taken only at the edge that sees ack.
  task wb_access(input logic w, input logic [7:0] a, input logic [31:0] d,
                 input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < LIMIT);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= LIMIT)
      timeout("bus ack");
  endtask : wb_access

  task rd_check(input logic [7:0] a, input logic [31:0] exp);
    wb_access(1'b0, a, 32'h0, 4'hf, junk);
    `CHECK($sformatf("register %0h", a), exp, junk)
  endtask : rd_check

  // Pulses one class of input for a cycle (kind 6 pulses smiReturnHalt and threadIrq); levels are kept.
  task strobe(input int k, input logic [NT-1:0] m, input logic [15:0] v);
    @(posedge clk);
    case (k)
      0:
      begin
        mwaitReq <= m;
        mwaitLevel <= {NT{v[2:0]}};
      end
      1: haltReq <= m;
      2: threadIrq <= m;
      3: monitorHit <= m;
      4: deadlineExpired <= m;
      5:
      begin
        legacyReadReq <= m;
        legacyReadAddr <= v;
      end
      6:
      begin
        smiReturnHalt <= m;
        threadIrq <= m;
      end
      7: pkgIrq <= 1'b1;
      8: snoopIn <= m[1:0];
      9: perfReqIn <= v[7:0];
      default: intMaskFlag <= m;
    endcase
    @(posedge clk);
    {mwaitReq, haltReq, threadIrq, monitorHit} <= '0;
    {deadlineExpired, legacyReadReq, smiReturnHalt, pkgIrq, snoopIn} <= '0;
    #1;
  endtask : strobe

  // Output picked by kind: thread, four core controls, restore, pll.
  function automatic logic [31:0] probe(input int k, input int i);
    case (k)
      0: probe = {31'h0, threadActive[i]};
      1: probe = {31'h0, cacheFlush[i]};
      2: probe = {31'h0, clockStop[i]};
      3: probe = {31'h0, stateSave[i]};
      4: probe = {31'h0, corePowerOff[i]};
      5: probe = {31'h0, stateRestore[i]};
      default: probe = {28'h0, pllTarget};
    endcase
  endfunction : probe

  // Bounded wait; long sequences have no fixed cycle figure.
  task wait_for(input int k, input int i, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (probe(k, i) !== v && n < LIMIT);
    totalChecks++;
    if (n >= LIMIT)
      timeout($sformatf("output %0d.%0d", k, i));
  endtask : wait_for

  // =====================================================================
  // Main sequence.
  initial
  begin
    {rst_b, cyc, stb, we, adr, sel, wdat, pkgIrq, snoopIn} = '0;
    {mwaitReq, haltReq, intMaskFlag, legacyReadReq, threadIrq} = '0;
    {monitorHit, deadlineExpired, smiReturnHalt, mwaitLevel} = '0;
    {legacyReadAddr, perfReqIn, nErrors, totalChecks} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    `CHECK("threadActive", 4'hf, threadActive)
    rd_check(`CIP_OFF_IOTRAP, 32'h0);
    rd_check(`CIP_OFF_IDLECFG, 32'h4);
    rd_check(`CIP_OFF_THRESH, 32'h0804);
    rd_check(8'h20, 32'h0);
    wb_access(1'b1, `CIP_OFF_THRESH, 32'h0a05, 4'hf, junk);
    rd_check(`CIP_OFF_THRESH, 32'h0a05);
    wb_access(1'b1, `CIP_OFF_IDLECFG, 32'h3, 4'h3, junk);
    rd_check(`CIP_OFF_IDLECFG, 32'h4);
    // Core 0: halt and clock-stop requests resolve to halt.
    strobe(0, 4'h1, 16'h1);
    `CHECK("threadActive", 4'he, threadActive)
    strobe(0, 4'h2, 16'h2);
    repeat (40) @(posedge clk);
    `CHECK("clockStop", 2'b00, clockStop)
    strobe(8, 4'h1, 16'h0);
    `CHECK("snoopServiced", 2'b01, snoopServiced)
    strobe(2, 4'h1, 16'h0);
    `CHECK("threadActive", 4'hd, threadActive)
    strobe(6, 4'h2, 16'h0);
    `CHECK("threadActive", 4'hd, threadActive)
    strobe(3, 4'h2, 16'h0);
    `CHECK("threadActive", 4'hf, threadActive)
    // Core 1: halt, then clock-stop with a snoop, then power-off.
    strobe(1, 4'hc, 16'h0);
    repeat (20) @(posedge clk);
    `CHECK("cacheFlush", 2'b00, cacheFlush)
    strobe(7, 4'h0, 16'h0);
    wait_for(0, 3, 1);
    strobe(0, 4'hc, 16'h2);
    wait_for(1, 1, 1);
    wait_for(2, 1, 1);
    strobe(8, 4'h2, 16'h0);
    `CHECK("snoopServiced", 2'b00, snoopServiced)
    `CHECK("threadActive", 4'h3, threadActive)
    strobe(4, 4'h4, 16'h0);
    wait_for(0, 2, 1);
    strobe(2, 4'h8, 16'h0);
    wait_for(0, 3, 1);
    strobe(0, 4'hc, 16'h5);
    wait_for(3, 1, 1);
    wait_for(4, 1, 1);
    strobe(7, 4'h0, 16'h0);
    wait_for(5, 1, 1);
    wait_for(0, 3, 1);
    // Legacy reads, trapped only when enabled and inside the range.
    strobe(5, 4'h1, 16'h0100);
    `CHECK("legacyReadPassThru", 4'h1, legacyReadPassThru)
    wb_access(1'b1, `CIP_OFF_IOTRAP, 32'h8004_0100, 4'hf, junk);
    strobe(5, 4'h2, 16'h0104);
    `CHECK("legacyReadPassThru", 4'h2, legacyReadPassThru)
    strobe(5, 4'h1, 16'h0101);
    `CHECK("legacyReadPassThru", 4'h0, legacyReadPassThru)
    `CHECK("threadActive", 4'he, threadActive)
    strobe(10, 4'h1, 16'h0);
    strobe(2, 4'h1, 16'h0);
    `CHECK("threadActive", 4'hf, threadActive)
    strobe(10, 4'h0, 16'h0);
    // Shared operating point: voltage first, later request deferred.
    strobe(9, 4'h0, 16'h0053);
    repeat (2) @(posedge clk);
    `CHECK("voltTarget", 4'h5, voltTarget)
    `CHECK("pllTarget", 4'h0, pllTarget)
    strobe(9, 4'h0, 16'h0073);
    `CHECK("voltTarget", 4'h5, voltTarget)
    wait_for(6, 0, 5);
    wait_for(6, 0, 7);
    strobe(1, 4'hc, 16'h0);
    strobe(9, 4'h0, 16'h0092);
    wait_for(6, 0, 2);
    strobe(7, 4'h0, 16'h0);
    wait_for(6, 0, 9);
    // Zero threshold: a power-off request falls back to clock-stop.
    wb_access(1'b1, `CIP_OFF_THRESH, 32'h0, 4'hf, junk);
    wb_access(1'b1, `CIP_OFF_IDLECFG, 32'h5, 4'hf, junk);
    strobe(0, 4'hc, 16'h7);
    wait_for(2, 1, 1);
    `CHECK("corePowerOff", 2'b00, corePowerOff)
    complete_run();
  end
endmodule : testbench
